// *** verilog/uef_pkg.sv ***
package uef_pkg;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_FLAGS = 8'h00;
  localparam logic [7:0] OFS_INT_EN = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_ERR_EN = 8'h0C;
  localparam logic [7:0] OFS_CTRL = 8'h10;
  // ----------------------------------------
  // flag bit positions
  // ----------------------------------------
  localparam int BIT_BUSRST = 0;
  localparam int BIT_ERR = 1;
  localparam int BIT_SOF = 2;
  localparam int BIT_TRN = 3;
  localparam int BIT_IDLE = 4;
  localparam int BIT_RESUME = 5;
  localparam int BIT_ATTACH = 6;
  localparam int BIT_STALL = 7;
  localparam int CTRL_HOST = 0;
  // ----------------------------------------
  // status fields
  // ----------------------------------------
  localparam int ST_PINGPONG_BANK_INDICATOR = 2;
  localparam int ST_DIR = 3;
  localparam int ST_EP_LO = 4;
  localparam int ST_W = 6;
  localparam int QDEPTH = 4;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] INT_EN_RST = 8'h00;
  localparam logic [7:0] ERR_EN_RST = 8'h00;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ = 200;
  localparam real QUIET_US = 2.5;
  localparam real K_US = 2.5;
  localparam int IDLE_MS = 3;
  localparam int QUIET_CYC = int'($ceil(QUIET_US * CLK_MHZ));
  localparam int K_CYC = int'($ceil(K_US * CLK_MHZ));
  localparam int IDLE_CYC = IDLE_MS * 1000 * CLK_MHZ;
  localparam int CNT_W = 20;
endpackage : uef_pkg

// *** verilog/uef_top.sv ***
// Functional notes
// - flag register bits 31..8 always read zero.
// - hardware sets flags; writing one clears a flag, zero leaves it.
// - host mode: received STALL handshake sets stall flag bit 7.
// - device mode: transmitted STALL handshake sets stall flag.
// - detected peripheral connection sets attach flag bit 6.
// - attach valid only with host enabled, 2.5 us quiet, bus not SE0.
// - K-state held 2.5 us on a data line sets resume flag bit 5.
// - idle bus for 3 ms or more sets idle flag bit 4.
// - finished token sets token-done bit 3; status shows its endpoint.
// - clearing token-done advances the transaction status queue.
// - SOF flag: device on SOF token, host on frame threshold.
// - error flag bit 1 only from errors enabled in error enable register.
// - device mode: valid USB reset sets bit 0.
// - host mode: peripheral detach sets bit 0.
// - status read-only: endpoint 7..4, direction 3, bank 2, rest zero.
// - status is head of four-entry queue, valid while token-done set.
// - direction reads one for transmit, zero for receive.
// - bank bit reads one for odd bank, zero for even.
//
// Decided for this implementation: the APB slave port and the register addresses.
module uef_top
  import uef_pkg::*;
#(
  parameter int IDLE_CYCLES = IDLE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial engine events, one-cycle pulses
  input wire logic stall_rx,
  input wire logic stall_tx,
  input wire logic sof_rx,
  input wire logic sof_threshold,
  input wire logic bus_reset_det,
  input wire logic detach_det,
  input wire logic [7:0] err_events,
  input wire logic token_done,
  input wire logic [3:0] token_endpoint,
  input wire logic token_dir_tx,
  input wire logic token_odd_bank,
  // line state levels
  input wire logic line_se0,
  input wire logic line_k,
  input wire logic line_idle,
  input wire logic bus_activity,
  // interrupt request
  output logic irq
);

  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  logic [7:0] int_en_r;
  logic [7:0] err_en_r;
  logic host_en_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic irq_r;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire access = psel & penable;
  wire done = access & pready_r;
  wire wr_done = done & pwrite;
  wire hit_flags = (paddr == OFS_FLAGS);
  wire hit_int_en = (paddr == OFS_INT_EN);
  wire hit_status = (paddr == OFS_STATUS);
  wire hit_err_en = (paddr == OFS_ERR_EN);
  wire hit_ctrl = (paddr == OFS_CTRL);
  wire mapped = hit_flags | hit_int_en | hit_status | hit_err_en | hit_ctrl;
  wire [7:0] clr_mask = (wr_done & hit_flags) ? pwdata[7:0] : 8'h00;

  // ----------------------------------------
  // transaction status queue
  // ----------------------------------------
  logic [ST_W-1:0] q_mem [QDEPTH];
  logic [1:0] q_rd_r;
  logic [1:0] q_wr_r;
  logic [2:0] q_cnt_r;
  wire q_full = (q_cnt_r == 3'(QDEPTH));
  wire q_nonempty = (q_cnt_r != 3'h0);
  // a completion when full is dropped: the engine must not outrun software
  wire q_push = token_done & ~q_full;
  wire q_pop = clr_mask[BIT_TRN] & q_nonempty;
  wire [ST_W-1:0] q_entry = {token_endpoint, token_dir_tx, token_odd_bank};
  wire [ST_W-1:0] q_head = q_mem[q_rd_r];
  wire [2:0] q_cnt_nxt = q_cnt_r + {2'h0, q_push} - {2'h0, q_pop};

  // storage left unreset so status contents are unknown after reset
  always_ff @(posedge clk) begin
    if (q_push) begin
      q_mem[q_wr_r] <= q_entry;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q_rd_r <= 2'h0;
    end else begin
      q_rd_r <= q_rd_r + {1'b0, q_pop};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q_wr_r <= 2'h0;
    end else begin
      q_wr_r <= q_wr_r + {1'b0, q_push};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q_cnt_r <= 3'h0;
    end else begin
      q_cnt_r <= q_cnt_nxt;
    end
  end

  // ----------------------------------------
  // line state timers
  // ----------------------------------------
  logic [CNT_W-1:0] quiet_cnt_r;
  logic [CNT_W-1:0] k_cnt_r;
  logic [CNT_W-1:0] idle_cnt_r;
  logic attach_armed_r;
  logic k_seen_r;
  logic idle_seen_r;

  wire quiet_met = (quiet_cnt_r >= CNT_W'(QUIET_CYC));
  wire k_met = (k_cnt_r >= CNT_W'(K_CYC));
  wire idle_met = (idle_cnt_r >= CNT_W'(IDLE_CYCLES));
  wire quiet_inc = ~bus_activity & ~quiet_met;
  wire k_inc = line_k & ~k_met;
  wire idle_inc = line_idle & ~idle_met;
  // attach armed out of reset, re-armed whenever the line is seen detached (SE0)
  // activity in the sampling cycle itself already breaks the quiet stretch
  wire attach_ev = host_en_r & quiet_met & ~bus_activity & ~line_se0 & attach_armed_r;
  wire resume_ev = k_met & ~k_seen_r;
  wire idle_ev = idle_met & ~idle_seen_r;

  // quiet time before attach; any activity restarts it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      quiet_cnt_r <= '0;
      attach_armed_r <= 1'b1;
    end else begin
      quiet_cnt_r <= bus_activity ? '0 : quiet_cnt_r + CNT_W'(quiet_inc);
      attach_armed_r <= line_se0 | (attach_armed_r & ~attach_ev);
    end
  end

  // one event per continuous stretch; re-armed when the stretch breaks
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      k_cnt_r <= '0;
      k_seen_r <= 1'b0;
    end else begin
      k_cnt_r <= line_k ? k_cnt_r + CNT_W'(k_inc) : '0;
      k_seen_r <= k_met;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      idle_cnt_r <= '0;
      idle_seen_r <= 1'b0;
    end else begin
      idle_cnt_r <= line_idle ? idle_cnt_r + CNT_W'(idle_inc) : '0;
      idle_seen_r <= idle_met;
    end
  end

  // ----------------------------------------
  // event sources
  // ----------------------------------------
  logic [7:0] set_mask;
  always_comb begin
    set_mask = 8'h00;
    set_mask[BIT_STALL] = host_en_r ? stall_rx : stall_tx;
    set_mask[BIT_ATTACH] = attach_ev;
    set_mask[BIT_RESUME] = resume_ev;
    set_mask[BIT_IDLE] = idle_ev;
    set_mask[BIT_SOF] = host_en_r ? sof_threshold : sof_rx;
    set_mask[BIT_ERR] = |(err_events & err_en_r);
    set_mask[BIT_BUSRST] = host_en_r ? detach_det : bus_reset_det;
  end

  // set wins over clear; token-done follows queue occupancy
  always_comb begin
    flags_nxt = (flags_r & ~clr_mask) | set_mask;
    flags_nxt[BIT_TRN] = (q_cnt_nxt != 3'h0);
  end

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flags_r <= FLAGS_RST;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      int_en_r <= INT_EN_RST;
    end else if (wr_done && hit_int_en) begin
      int_en_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      err_en_r <= ERR_EN_RST;
    end else if (wr_done && hit_err_en) begin
      err_en_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      host_en_r <= 1'b0;
    end else if (wr_done && hit_ctrl) begin
      host_en_r <= pwdata[CTRL_HOST];
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  // head is stale once the queue drains; software checks token-done first
  logic [7:0] status_rd;
  always_comb begin
    status_rd = 8'h00;
    status_rd[ST_EP_LO +: 4] = q_head[5:2];
    status_rd[ST_DIR] = q_head[1];
    status_rd[ST_PINGPONG_BANK_INDICATOR] = q_head[0];
  end
  logic [31:0] rd_mux;
  always_comb begin
    if (hit_flags) begin
      rd_mux = {24'h000000, flags_r};
    end else if (hit_int_en) begin
      rd_mux = {24'h000000, int_en_r};
    end else if (hit_status) begin
      rd_mux = {24'h000000, status_rd};
    end else if (hit_err_en) begin
      rd_mux = {24'h000000, err_en_r};
    end else if (hit_ctrl) begin
      rd_mux = {31'h00000000, host_en_r};
    end else begin
      rd_mux = 32'h00000000;
    end
  end

  // ----------------------------------------
  // apb response: one wait state, outputs from flops
  // ----------------------------------------
  wire start = access & ~pready_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      pready_r <= start;
      pslverr_r <= start & ~mapped;
      prdata_r <= (start & ~pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // ----------------------------------------
  // interrupt request
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(flags_nxt & int_en_r);
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;

endmodule : uef_top

// *** test/uef_usb_far.sv ***
module uef_usb_far (
  // clock
  input wire logic clk,
  // toward the block
  output logic [6:0] ev,
  output logic [7:0] err,
  output logic [5:0] tok,
  output logic [3:0] ln
);
  timeunit 1ns;
  timeprecision 1ps;
  // bus busy by default so attach cannot fire by accident
  initial {ev, err, tok, ln} = {7'h00, 8'h00, 6'h00, 4'h1};
  // one-cycle strobes
  task automatic fire(input logic [6:0] m, input logic [7:0] e);
    ev <= m;
    err <= e;
    @(posedge clk);
    ev <= 7'h00;
    err <= 8'h00;
  endtask : fire
  // fields turn over once the strobe is gone
  task automatic token(input logic [5:0] t);
    tok <= t;
    ev[6] <= 1'b1;
    @(posedge clk);
    ev[6] <= 1'b0;
    tok <= ~t;
    @(posedge clk);
  endtask : token
  // bus silent n cycles, parked in SE0 or not
  task automatic quiet(input logic se0, input int n);
    ln <= {se0, 3'b000};
    repeat (n) @(posedge clk);
    ln <= 4'h1;
  endtask : quiet
  // line level held n cycles
  task automatic hold(input int i, input logic v, input int n);
    ln[i] <= v;
    repeat (n) @(posedge clk);
    ln[i] <= ~v;
  endtask : hold
endmodule : uef_usb_far

// *** test/uef_top_properties.sv ***
module uef_top_properties
  import uef_pkg::*;
(
  // apb
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // events
  input wire logic token_done,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  wire rd_fl = pready && !pwrite && paddr == OFS_FLAGS;
  wire rd_st = pready && !pwrite && paddr == OFS_STATUS;
  wire mapped = paddr inside {OFS_FLAGS, OFS_INT_EN, OFS_STATUS, OFS_ERR_EN, OFS_CTRL};
  one_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after one wait state");
  ack_pulse_a: assert property (pready |=> !pready) else $error("pready held too long");
  ack_cause_a: assert property (pready |-> $past(psel && penable)) else $error("stray pready");
  map_error_a: assert property (pready |-> pslverr == !mapped) else $error("bad pslverr");
  err_pair_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  quiet_data_a: assert property (!pready || pwrite |-> prdata == 32'h0)
    else $error("prdata outside a read answer");
  flag_upper_a: assert property (rd_fl |-> prdata[31:8] == 24'h0)
    else $error("flag upper bits set");
  stat_unused_a: assert property (rd_st |-> prdata[31:8] == 24'h0 && prdata[1:0] == 2'h0)
    else $error("status unused bits set");
  irq_reset_a: assert property (!$past(rstn) |-> !irq) else $error("irq after reset");
  irq_clear_a: assert property ($fell(irq) |-> $past(pready && pwrite) ||
    $past(pready && pwrite, 2)) else $error("irq dropped without a write");
  cover property (token_done);
  cover property (pslverr);
  cover property ($fell(irq));
endmodule : uef_top_properties
bind uef_top uef_top_properties props (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .token_done(token_done), .irq(irq));

// *** test/usb_event_flags_and_status_test.sv ***
module usb_event_flags_and_status_test import uef_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, irq, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0] ev;
  logic [7:0] err;
  logic [5:0] tok;
  logic [3:0] ln;
  int miscompares = 0;
  int tests_run = 0;
  // host, event strobes, error sources, expected flags
  logic [23:0] rows [16] = '{24'h810080, 24'h020080, 24'h040004, 24'h880004, 24'h100001,
    24'hA00001, 24'h000102, 24'h000200, 24'h000402, 24'h000702, 24'h820000, 24'h010000,
    24'h080000, 24'h840000, 24'h200000, 24'h900000};
  uef_top #(.IDLE_CYCLES(50)) uut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .stall_rx(ev[0]), .stall_tx(ev[1]), .sof_rx(ev[2]),
    .sof_threshold(ev[3]), .bus_reset_det(ev[4]), .detach_det(ev[5]), .err_events(err),
    .token_done(ev[6]), .token_endpoint(tok[5:2]), .token_dir_tx(tok[1]),
    .token_odd_bank(tok[0]), .line_se0(ln[3]), .line_k(ln[2]), .line_idle(ln[1]),
    .bus_activity(ln[0]), .irq(irq));
  uef_usb_far far (.clk(clk), .ev(ev), .err(err), .tok(tok), .ln(ln));
  task automatic end_sim;
    $display("checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h, want %h", $time, got, exp);
    end
  endtask : chk
  // entered just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      miscompares++;
      end_sim();
    end
    @(posedge clk);
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    logic [5:0] t;
    {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rdc(OFS_FLAGS, 32'h0);
    apb(1'b1, OFS_FLAGS, 32'hFFFFFFFF);
    rdc(OFS_FLAGS, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, OFS_ERR_EN, 32'h05);
    apb(1'b1, OFS_INT_EN, 32'hDF); // resume irq kept off outside suspend
    foreach (rows[i]) begin
      apb(1'b1, OFS_CTRL, {31'h0, rows[i][23]});
      far.fire(rows[i][22:16], rows[i][15:8]);
      rdc(OFS_FLAGS, {24'h0, rows[i][7:0]});
      chk({31'h0, irq}, {31'h0, |rows[i][7:0]});
      apb(1'b1, OFS_FLAGS, {24'h0, ~rows[i][7:0]});
      rdc(OFS_FLAGS, {24'h0, rows[i][7:0]});
      apb(1'b1, OFS_FLAGS, {24'h0, rows[i][7:0]});
      rdc(OFS_FLAGS, 32'h0);
    end
    apb(1'b1, OFS_CTRL, 32'h0);
    for (int i = 0; i < 5; i++)
      far.token(6'h3E - 6'(i * 13)); // fifth must be dropped
    for (int i = 0; i < 4; i++) begin
      t = 6'h3E - 6'(i * 13);
      rdc(OFS_FLAGS, 32'h08);
      rdc(OFS_STATUS, {24'h0, t, 2'h0});
      apb(1'b1, OFS_FLAGS, 32'h08);
    end
    rdc(OFS_FLAGS, 32'h0);
    apb(1'b1, OFS_INT_EN, 32'h0);
    far.hold(2, 1'b1, 490);
    rdc(OFS_FLAGS, 32'h0);
    far.hold(2, 1'b1, 510);
    rdc(OFS_FLAGS, 32'h20);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, OFS_FLAGS, 32'h20);
    far.hold(1, 1'b1, 40);
    rdc(OFS_FLAGS, 32'h0);
    far.hold(1, 1'b1, 60);
    rdc(OFS_FLAGS, 32'h10);
    apb(1'b1, OFS_FLAGS, 32'h10);
    far.hold(0, 1'b0, 510);
    rdc(OFS_FLAGS, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h1);
    far.quiet(1'b1, 510);
    rdc(OFS_FLAGS, 32'h0);
    far.hold(3, 1'b1, 10);
    far.hold(0, 1'b0, 510);
    rdc(OFS_FLAGS, 32'h40);
    apb(1'b1, OFS_INT_EN, 32'h48);
    far.token(6'h15);
    rdc(OFS_STATUS, 32'h54);
    chk({31'h0, irq}, 32'h1);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rdc(OFS_FLAGS, 32'h0);
    rdc(OFS_INT_EN, 32'h0);
    chk({31'h0, irq}, 32'h0);
    end_sim();
  end
endmodule : usb_event_flags_and_status_test
